// [bench/gdr_top_tb.sv]
// Self-checking bench for the GPIO data register bank, checked against a behavioural model
`timescale 1ns/1ps
module gdr_top_tb;
  // ----------------------------------------------------------------
  // Signals, model state and counters
  // ----------------------------------------------------------------
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic [47:0] pin_in;
  logic [47:0] pin_out;
  logic [47:0] pin_oe_n;
  logic [7:0] cfg_m [48]; // Model configuration bytes
  logic [47:0] data_m; // Model of last written output bits
  integer seed = 84; // Fixed seed for repeatable stimulus
  int fails;
  int checked;

  gdr_top u_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .RD_I(rd), .WR_I(wr), .WDATA_I(wdata),
    .RDATA_O(rdata), .RVALID_O(rvalid), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_N_O(pin_oe_n));

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count; report a mismatch at once
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Final report and end of run
  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One write access, held for exactly one taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk); #1;
    wr = 1'b0;
  endtask

  // One read access; the answer strobe comes one edge after the taking edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk); #1;
    rd = 1'b0;
    @(posedge clk);
    #1;
    chk({47'h0, rvalid}, 48'h1);
    d = rdata;
    @(posedge clk);
    #1;
    chk({47'h0, rvalid}, 48'h0);
  endtask

  // Expected group value: pin level through polarity for inputs, last write for outputs
  function automatic logic [7:0] exp_grp(input int g);
    logic [7:0] v;
    int i;
    for (int b = 0; b < 8; b++) begin
      i = 8 * g + b;
      if (!gdr_pkg::PIN_PRESENT[i]) v[b] = 1'b0;
      else if (cfg_m[i][gdr_pkg::CFG_DIR_BIT]) v[b] = pin_in[i] ^ cfg_m[i][gdr_pkg::CFG_POL_BIT];
      else v[b] = data_m[i];
    end
    return v;
  endfunction

  // Pin drive check: value is data through polarity, open drain releases a one
  task automatic chk_pins;
    logic [47:0] val;
    logic [47:0] drv;
    for (int i = 0; i < 48; i++) begin
      val[i] = data_m[i] ^ cfg_m[i][gdr_pkg::CFG_POL_BIT];
      drv[i] = gdr_pkg::PIN_PRESENT[i] & ~cfg_m[i][gdr_pkg::CFG_DIR_BIT];
      drv[i] = drv[i] & ~(cfg_m[i][gdr_pkg::CFG_OTYPE_BIT] & val[i]);
    end
    chk(pin_oe_n, ~drv);
    chk(pin_out & drv, val & drv);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] r;
    logic [7:0] d;
    logic [31:0] hi;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin_in = 48'h0;
    data_m = 48'h0;
    fails = 0;
    checked = 0;
    for (int i = 0; i < 48; i++) cfg_m[i] = gdr_pkg::CFG_RESET;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(pin_oe_n, {48{1'b1}});
    // Rounds: first keeps reset configuration, later ones randomise it
    for (int rnd = 0; rnd < 6; rnd++) begin
      for (int i = 0; i < 48; i++) begin
        if (rnd > 0) begin
          cfg_m[i] = 8'($random(seed));
          wr_reg(gdr_pkg::CFG_BASE_OFS + 8'(i), cfg_m[i]);
        end
        rd_reg(gdr_pkg::CFG_BASE_OFS + 8'(i), r);
        chk({40'h0, r}, {40'h0, cfg_m[i]});
      end
      // Data writes: only present output bits take the value
      for (int g = 0; g < 6; g++) begin
        d = 8'($random(seed));
        wr_reg(gdr_pkg::DATA_GROUP1_OFS + 8'(g), d);
        for (int b = 0; b < 8; b++) begin
          if (gdr_pkg::PIN_PRESENT[8 * g + b] && !cfg_m[8 * g + b][gdr_pkg::CFG_DIR_BIT]) data_m[8 * g + b] = d[b];
        end
      end
      hi = $random(seed);
      pin_in = {hi[15:0], $random(seed)};
      repeat (3) @(posedge clk);
      #1;
      chk_pins;
      for (int g = 0; g < 6; g++) begin
        rd_reg(gdr_pkg::DATA_GROUP1_OFS + 8'(g), r);
        chk({40'h0, r}, {40'h0, exp_grp(g)});
      end
      // Turn every pin into an output: bits written while it was an input must not show
      for (int i = 0; i < 48; i++) begin
        cfg_m[i][gdr_pkg::CFG_DIR_BIT] = 1'b0;
        wr_reg(gdr_pkg::CFG_BASE_OFS + 8'(i), cfg_m[i]);
      end
      repeat (2) @(posedge clk);
      #1;
      chk_pins;
      for (int g = 0; g < 6; g++) begin
        rd_reg(gdr_pkg::DATA_GROUP1_OFS + 8'(g), r);
        chk({40'h0, r}, {40'h0, exp_grp(g)});
      end
    end
    // Unmapped offsets: writes dropped, reads zero
    wr_reg(8'h51, 8'hFF);
    wr_reg(8'h4A, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      rd_reg(k == 0 ? 8'h30 : k == 1 ? 8'h4A : k == 2 ? 8'h51 : 8'hFF, r);
      chk({40'h0, r}, 48'h0);
    end
    repeat (2) @(posedge clk);
    #1;
    chk_pins;
    give_verdict;
  end

  // Hang guard
  initial begin
    #(40 * 100000);
    fails++;
    give_verdict;
  end
endmodule

// [logic/gdr_cfg_mem.sv]
// Small register-read memory holding the per-pin configuration bytes
`timescale 1ns/1ps
module gdr_cfg_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [5:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  output logic [47:0] dir_o,
  output logic [47:0] pol_o,
  output logic [47:0] otype_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [gdr_pkg::PINS];             // One byte per pin slot

  // Write port and reset of every entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < gdr_pkg::PINS; n++) begin
        cfg_q[n] <= gdr_pkg::CFG_RESET;
      end
    end else if (wr_en_i && (int'(wr_idx_i) < gdr_pkg::PINS)) begin
      cfg_q[wr_idx_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (int'(rd_idx_i) < gdr_pkg::PINS) begin
      rd_data_o <= cfg_q[rd_idx_i];
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // Field fan-out to the pin logic
  genvar g;
  generate
    for (g = 0; g < gdr_pkg::PINS; g++) begin : g_fld
      assign dir_o[g] = cfg_q[g][gdr_pkg::CFG_DIR_BIT];
      assign pol_o[g] = cfg_q[g][gdr_pkg::CFG_POL_BIT];
      assign otype_o[g] = cfg_q[g][gdr_pkg::CFG_OTYPE_BIT];
    end
  endgenerate

endmodule

// [logic/gdr_top.sv]
// GPIO data register bank: six data registers, per-pin configuration and pin drive
`timescale 1ns/1ps
module gdr_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  input wire logic [47:0] PIN_I,
  output logic [47:0] PIN_O,
  output logic [47:0] PIN_OE_N_O
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic data_hit; // Access falls on a data register
  logic cfg_hit; // Access falls on a configuration register
  logic [2:0] grp; // Data register group index 0..5
  logic [5:0] cfg_idx; // Configuration slot index
  logic [47:0] dir; // 1 input
  logic [47:0] pol; // 1 inverted
  logic [47:0] otype; // 1 open drain
  logic [7:0] cfg_rd; // Registered configuration read data
  logic [47:0] pin_val; // Pin level after polarity
  logic [47:0] data_q; // Stored output data bits
  logic [47:0] latch_q; // Data bits latched at access
  logic rd_data_q; // Last read hit a data register
  logic rd_cfg_q; // Last read hit a configuration register
  logic [2:0] rd_grp_q; // Group of last data read
  logic rvalid_q; // Read answer strobe

  // Decode of data and configuration windows
  always_comb begin
    data_hit = (ADDR_I >= gdr_pkg::DATA_GROUP1_OFS) && (ADDR_I <= gdr_pkg::DATA_GROUP6_OFS);
    grp = 3'(ADDR_I - gdr_pkg::DATA_GROUP1_OFS);
    cfg_idx = 6'(ADDR_I - gdr_pkg::CFG_BASE_OFS);
    // Range test on the full offset, so offsets at 0x40 and up never alias onto a slot
    cfg_hit = (ADDR_I >= gdr_pkg::CFG_BASE_OFS) && (ADDR_I < (gdr_pkg::CFG_BASE_OFS + 8'(gdr_pkg::PINS)));
  end

  // ----------------------------------------------------------------
  // Configuration memory
  // ----------------------------------------------------------------
  // One byte per pin slot, fields fanned out per pin and
  gdr_cfg_mem u_cfg (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wr_en_i(WR_I && cfg_hit),
    .wr_idx_i(cfg_idx),
    .wr_data_i(WDATA_I),
    .rd_idx_i(cfg_idx),
    .rd_data_o(cfg_rd),
    .dir_o(dir),
    .pol_o(pol),
    .otype_o(otype)
  );

  // ----------------------------------------------------------------
  // Pin value seen by software
  // ----------------------------------------------------------------
  // Polarity applied on the input path
  assign pin_val = PIN_I ^ pol;

  // ----------------------------------------------------------------
  // Data bits
  // ----------------------------------------------------------------
  // Output data store: only output pins present take a write
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      data_q <= {gdr_pkg::GROUPS{gdr_pkg::DATA_RESET}};
    end else if (WR_I && data_hit) begin
      for (int b = 0; b < 8; b++) begin
        if (gdr_pkg::PIN_PRESENT[8 * grp + b] && !dir[8 * grp + b]) begin
          data_q[8 * grp + b] <= WDATA_I[b];
        end
      end
    end
  end

  // Access latch: a read or write of a group captures its bits
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      latch_q <= '0;
    end else if ((RD_I || WR_I) && data_hit) begin
      for (int b = 0; b < 8; b++) begin
        if (!gdr_pkg::PIN_PRESENT[8 * grp + b]) begin
          latch_q[8 * grp + b] <= 1'b0;
        end else if (dir[8 * grp + b]) begin
          latch_q[8 * grp + b] <= pin_val[8 * grp + b];
        end else if (WR_I) begin
          latch_q[8 * grp + b] <= WDATA_I[b];
        end else begin
          latch_q[8 * grp + b] <= data_q[8 * grp + b];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Remember what the read targeted
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rd_data_q <= 1'b0;
      rd_cfg_q <= 1'b0;
      rd_grp_q <= 3'h0;
      rvalid_q <= 1'b0;
    end else begin
      rd_data_q <= RD_I && data_hit;
      rd_cfg_q <= RD_I && cfg_hit;
      rd_grp_q <= grp;
      rvalid_q <= RD_I;
    end
  end

  // Output register: answer one cycle after the latch/memory stage
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= rvalid_q;
      if (rd_data_q) begin
        RDATA_O <= latch_q[8 * rd_grp_q +: 8];
      end else if (rd_cfg_q) begin
        RDATA_O <= cfg_rd;
      end else begin
        RDATA_O <= 8'h00; // Unmapped offsets read zero
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Per-pin driver: push pull drives both levels, open drain only low
  genvar p;
  generate
    for (p = 0; p < gdr_pkg::PINS; p++) begin : g_pin
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          PIN_O[p] <= 1'b0;
          PIN_OE_N_O[p] <= 1'b1;
        end else begin
          PIN_O[p] <= data_q[p] ^ pol[p];
          PIN_OE_N_O[p] <= !gdr_pkg::PIN_PRESENT[p] || dir[p] ||
                           (otype[p] && (data_q[p] ^ pol[p]));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_input_write_ignored: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_I && data_hit && dir[8 * grp]) |=> (data_q[8 * $past(grp)] == $past(data_q[8 * grp])))
    else $error("write changed an input pin data bit");

  a_output_write_stored: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_I && data_hit && !dir[8 * grp]) |=> (data_q[8 * $past(grp)] == $past(WDATA_I[0])))
    else $error("write to output pin not stored");

  a_pin_drives_data: assert property (@(posedge CLK_I) disable iff (RST_I)
    ##1 (PIN_O[0] == $past(data_q[0] ^ pol[0])))
    else $error("pin drive does not follow data and polarity");

  a_input_not_driven: assert property (@(posedge CLK_I) disable iff (RST_I)
    dir[0] |=> PIN_OE_N_O[0])
    else $error("input pin driven");

  a_output_pushpull_drive: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!dir[0] && !otype[0]) |=> !PIN_OE_N_O[0])
    else $error("push pull output not driven");

  a_reserved_reads_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    (RD_I && ADDR_I == gdr_pkg::DATA_GROUP6_OFS) |=> ##1 (RDATA_O[7:2] == 6'h00))
    else $error("reserved bits read nonzero");

  a_read_answer_time: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I |=> ##1 RVALID_O)
    else $error("read answer not two cycles later");

  a_input_read_latched: assert property (@(posedge CLK_I) disable iff (RST_I)
    (RD_I && ADDR_I == gdr_pkg::DATA_GROUP1_OFS && dir[0]) |=> ##1 (RDATA_O[0] == $past(pin_val[0], 2)))
    else $error("input read does not return latched pin");

  a_output_read_last: assert property (@(posedge CLK_I) disable iff (RST_I)
    (RD_I && !WR_I && ADDR_I == gdr_pkg::DATA_GROUP1_OFS && !dir[0]) |=> ##1 (RDATA_O[0] == $past(data_q[0], 2)))
    else $error("output read does not return last write");

  // A data register write must leave every configuration field alone
  a_data_write_no_cfg: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_I && data_hit) |=> ((dir == $past(dir)) && (pol == $past(pol)) && (otype == $past(otype))))
    else $error("data register write changed configuration");

  a_unmapped_read_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    (RD_I && !data_hit && !cfg_hit) |=> ##1 (RDATA_O == 8'h00))
    else $error("unmapped offset read nonzero");

  a_write_data_latched: assert property (@(posedge CLK_I) disable iff (RST_I)
    (WR_I && ADDR_I == gdr_pkg::DATA_GROUP1_OFS && !dir[0]) |=> (latch_q[0] == $past(WDATA_I[0])))
    else $error("write to output pin not latched");

  // Slot 11 (group 2 bit 3) and slot 47 (group 6 bit 7) have no pin behind them
  a_reserved_slot_released: assert property (@(posedge CLK_I) disable iff (RST_I)
    PIN_OE_N_O[11] && PIN_OE_N_O[47])
    else $error("reserved pin slot driven");

  a_opendrain_high_released: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!dir[0] && otype[0] && (data_q[0] ^ pol[0])) |=> PIN_OE_N_O[0])
    else $error("open drain output drives a one");

endmodule

// [shared/gdr_pkg.sv]
// Package with offsets, field positions and reset values of the GPIO data register bank
package gdr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int GROUPS = 6;                      // Number of data registers
  localparam int PINS = 48;                       // Pin slots, eight per group
  localparam int ADDR_W = 8;                      // Offset width from block base

  // ----------------------------------------------------------------
  // Data register offsets from the power event block base
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_GROUP1_OFS = 8'h4B;
  localparam logic [7:0] DATA_GROUP2_OFS = 8'h4C;
  localparam logic [7:0] DATA_GROUP3_OFS = 8'h4D;
  localparam logic [7:0] DATA_GROUP4_OFS = 8'h4E;
  localparam logic [7:0] DATA_GROUP5_OFS = 8'h4F;
  localparam logic [7:0] DATA_GROUP6_OFS = 8'h50;

  // Configuration registers: one per pin slot, slot n at CFG_BASE_OFS + n
  localparam logic [7:0] CFG_BASE_OFS = 8'h00;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_DIR_BIT = 0;                 // 1 input, 0 output
  localparam int CFG_POL_BIT = 1;                 // 1 inverted
  localparam int CFG_OTYPE_BIT = 7;               // 1 open drain, 0 push pull

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h01;       // Non-inverted push-pull input
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Pins present behind each data register (zero bits are reserved)
  localparam logic [47:0] PIN_PRESENT = {8'h03, 8'hFF, 8'h0F, 8'hFF, 8'hF7, 8'hFF};

endpackage
